// >>> logic/cbs_pkg.sv
// constants shared by the bus sizing bridge
package cbs_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int SYS_ADDR_HI = 19;
    localparam int HIGH_ADDR_LO = 17;
    localparam int HIGH_ADDR_HI = 23;
    localparam int PERIPH_ADDR_HI = 16;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [23:0] ADDR_RESET = 24'h00_0000;

    typedef enum logic [2:0] {
        CBS_IDLE = 3'b000,
        CBS_WIDE = 3'b001,
        CBS_LOW = 3'b010,
        CBS_HIGH = 3'b011,
        CBS_DONE = 3'b100
    } cbs_state_t;
endpackage

// >>> logic/cbs_addr_latch.sv
// address latch and unlatched high address buffer
`timescale 1ns/100ps
module cbs_addr_latch (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic addrStrobe,
    input wire logic [cbs_pkg::ADDR_W-1:0] cpuAddr,
    output logic [cbs_pkg::SYS_ADDR_HI:1] latchedSystemAddress,
    output logic [cbs_pkg::HIGH_ADDR_HI:cbs_pkg::HIGH_ADDR_LO] unlatchedHighAddress
);
    import cbs_pkg::*;

    logic [SYS_ADDR_HI:1] sysAddr_ff;
    logic [HIGH_ADDR_HI:HIGH_ADDR_LO] highAddr_ff;

    // latched copy held for the whole cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sysAddr_ff <= ADDR_RESET[SYS_ADDR_HI:1];
        end else if (clkEn && addrStrobe) begin
            sysAddr_ff <= cpuAddr[SYS_ADDR_HI:1];
        end
    end

    // unlatched: follows the processor every cycle with clkEn high, one register stage only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            highAddr_ff <= ADDR_RESET[HIGH_ADDR_HI:HIGH_ADDR_LO];
        end else if (clkEn) begin
            highAddr_ff <= cpuAddr[HIGH_ADDR_HI:HIGH_ADDR_LO];
        end
    end

    assign latchedSystemAddress = sysAddr_ff;
    assign unlatchedHighAddress = highAddr_ff;

    a_high_follows: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn |=> unlatchedHighAddress == $past(cpuAddr[HIGH_ADDR_HI:HIGH_ADDR_LO]))
        else $error("unlatched high address did not follow processor");
    a_latch_holds: assert property (@(posedge sys_clk) disable iff (rst)
        !(clkEn && addrStrobe) |=> $stable(latchedSystemAddress))
        else $error("latched address changed without strobe");
endmodule

// >>> logic/cbs_bridge.sv
// processor to system bus sizing bridge with byte splitting
`timescale 1ns/100ps
module cbs_bridge (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic cpuReq,
    input wire logic cpuWrite,
    input wire logic cpuWord,
    input wire logic cpuMem,
    input wire logic target8,
    input wire logic dmaActive,
    input wire logic [cbs_pkg::ADDR_W-1:0] cpuAddr,
    input wire logic [cbs_pkg::DATA_W-1:0] processorDataBusIn,
    input wire logic [cbs_pkg::DATA_W-1:0] systemDataBusIn,
    input wire logic [cbs_pkg::DATA_W-1:0] memoryDataBusIn,
    input wire logic [cbs_pkg::BYTE_W-1:0] onboardPeripheralDataIn,
    input wire logic [cbs_pkg::PERIPH_ADDR_HI:1] onboardPeripheralAddressIn,
    output logic cpuAck,
    output logic [cbs_pkg::DATA_W-1:0] processorDataBus,
    output logic [cbs_pkg::ADDR_W-1:0] systemAddress,
    output logic [cbs_pkg::SYS_ADDR_HI:1] latchedSystemAddress,
    output logic [cbs_pkg::HIGH_ADDR_HI:cbs_pkg::HIGH_ADDR_LO] unlatchedHighAddress,
    output logic [cbs_pkg::PERIPH_ADDR_HI:1] onboardPeripheralAddress,
    output logic onboardPeripheralAddressOe,
    output logic [cbs_pkg::DATA_W-1:0] systemDataBus,
    output logic systemDataBusOe,
    output logic [cbs_pkg::DATA_W-1:0] memoryDataBus,
    output logic memoryDataBusOe,
    output logic [cbs_pkg::BYTE_W-1:0] onboardPeripheralData,
    output logic onboardPeripheralDataOe,
    output logic periphStrobe,
    output logic periphWrite,
    output logic periphA0
);
    import cbs_pkg::*;

    // ****************************************
    // state and registers
    // ****************************************
    cbs_state_t state_ff, nxt_state;
    logic write_ff, mem_ff, word_ff, a0_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [BYTE_W-1:0] lowByte_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic ack_ff, strobe_ff, pwrite_ff, pa0_ff;
    logic [BYTE_W-1:0] pdata_ff;
    logic pdataOe_ff, sdOe_ff, mdOe_ff;
    logic [DATA_W-1:0] sd_ff, md_ff;
    logic [ADDR_W-1:0] fullAddr_ff;
    logic [PERIPH_ADDR_HI:1] xa_ff;
    logic xaOe_ff;
    logic dmaS1_ff, dmaS2_ff;

    // ****************************************
    // decode
    // ****************************************
    wire startReq = clkEn && cpuReq && state_ff == CBS_IDLE;
    // split only a non-memory word to a byte-wide target; everything else passes once
    wire needSplit = cpuWord && target8 && !cpuMem;
    wire isWideCycle = state_ff == CBS_WIDE;
    wire isLowCycle = state_ff == CBS_LOW;
    wire isHighCycle = state_ff == CBS_HIGH;
    wire byteCycle = isLowCycle || isHighCycle;
    // start edge uses the request itself: the captured copies only land on that edge
    wire curWrite = startReq ? cpuWrite : write_ff;
    wire [DATA_W-1:0] curWdata = startReq ? processorDataBusIn : wdata_ff;
    wire nxtByteCycle = nxt_state == CBS_LOW || nxt_state == CBS_HIGH;
    wire nxtNarrow = nxt_state == CBS_WIDE && !cpuMem && target8;
    // a byte access picks its lane from address bit zero
    wire nxtHighLane = nxt_state == CBS_HIGH || (nxt_state == CBS_WIDE && cpuAddr[0]);
    wire [BYTE_W-1:0] writeByte = nxtHighLane ? curWdata[DATA_W-1:BYTE_W] : curWdata[BYTE_W-1:0];
    wire [DATA_W-1:0] wideRead = mem_ff ? memoryDataBusIn : systemDataBusIn;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CBS_IDLE: begin
                if (startReq) begin
                    nxt_state = needSplit ? CBS_LOW : CBS_WIDE;
                end
            end
            CBS_WIDE: nxt_state = CBS_DONE;
            CBS_LOW: nxt_state = CBS_HIGH;
            CBS_HIGH: nxt_state = CBS_DONE;
            CBS_DONE: nxt_state = CBS_IDLE;
            default: nxt_state = CBS_IDLE;
        endcase
    end

    // ****************************************
    // address path
    // ****************************************
    cbs_addr_latch u_addr (
        .sys_clk(sys_clk),
        .rst(rst),
        .clkEn(clkEn),
        .addrStrobe(startReq),
        .cpuAddr(cpuAddr),
        .latchedSystemAddress(latchedSystemAddress),
        .unlatchedHighAddress(unlatchedHighAddress)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= CBS_IDLE;
            write_ff <= 1'b0;
            mem_ff <= 1'b0;
            word_ff <= 1'b0;
            a0_ff <= 1'b0;
            wdata_ff <= DATA_RESET;
            fullAddr_ff <= ADDR_RESET;
        end else if (clkEn) begin
            state_ff <= nxt_state;
            if (startReq) begin
                write_ff <= cpuWrite;
                mem_ff <= cpuMem;
                word_ff <= cpuWord;
                a0_ff <= cpuAddr[0];
                wdata_ff <= processorDataBusIn;
                fullAddr_ff <= cpuAddr;
            end
        end
    end

    // dma level comes from another bus master: two-stage sync
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dmaS1_ff <= 1'b0;
            dmaS2_ff <= 1'b0;
            xa_ff <= '0;
            xaOe_ff <= 1'b1;
        end else if (clkEn) begin
            dmaS1_ff <= dmaActive;
            dmaS2_ff <= dmaS1_ff;
            xaOe_ff <= !dmaS2_ff;
            xa_ff <= dmaS2_ff ? xa_ff : latchedSystemAddress[PERIPH_ADDR_HI:1];
        end
    end

    // ****************************************
    // data path
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lowByte_ff <= '0;
            rdata_ff <= DATA_RESET;
            ack_ff <= 1'b0;
            strobe_ff <= 1'b0;
            pwrite_ff <= 1'b0;
            pa0_ff <= 1'b0;
            pdata_ff <= '0;
            pdataOe_ff <= 1'b0;
            sdOe_ff <= 1'b0;
            mdOe_ff <= 1'b0;
            sd_ff <= DATA_RESET;
            md_ff <= DATA_RESET;
        end else if (clkEn) begin
            ack_ff <= nxt_state == CBS_DONE;
            strobe_ff <= nxtByteCycle || nxtNarrow;
            pwrite_ff <= curWrite;
            // low byte first, then high byte on the odd address
            pa0_ff <= nxtHighLane;
            // write data launches with the strobe so the target sees both in one cycle
            pdataOe_ff <= (nxtByteCycle || nxtNarrow) && curWrite;
            pdata_ff <= writeByte;
            mdOe_ff <= nxt_state == CBS_WIDE && cpuMem && curWrite;
            md_ff <= curWdata;
            sdOe_ff <= (nxt_state == CBS_WIDE && curWrite) || (byteCycle && !write_ff);
            sd_ff <= curWrite ? curWdata
                : (isHighCycle ? {onboardPeripheralDataIn, lowByte_ff}
                : {{BYTE_W{1'b0}}, onboardPeripheralDataIn});
            if (isLowCycle && !write_ff) begin
                lowByte_ff <= onboardPeripheralDataIn;
            end
            if (isHighCycle && !write_ff) begin
                rdata_ff <= {onboardPeripheralDataIn, lowByte_ff};
            end else if (isWideCycle && !write_ff) begin
                // byte access to a byte target returns the byte on both lanes
                rdata_ff <= (target8 && !mem_ff && !word_ff)
                    ? {onboardPeripheralDataIn, onboardPeripheralDataIn} : wideRead;
            end
        end
    end

    assign cpuAck = ack_ff;
    assign processorDataBus = rdata_ff;
    assign systemAddress = fullAddr_ff;
    assign onboardPeripheralAddress = xa_ff;
    assign onboardPeripheralAddressOe = xaOe_ff;
    assign systemDataBus = sd_ff;
    assign systemDataBusOe = sdOe_ff;
    assign memoryDataBus = md_ff;
    assign memoryDataBusOe = mdOe_ff;
    assign onboardPeripheralData = pdata_ff;
    assign onboardPeripheralDataOe = pdataOe_ff;
    assign periphStrobe = strobe_ff;
    assign periphWrite = pwrite_ff;
    assign periphA0 = pa0_ff;

    // ****************************************
    // checks
    // ****************************************
    a_split_order: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && state_ff == CBS_LOW) |=> state_ff == CBS_HIGH || !clkEn)
        else $error("byte split did not move to high byte");
    a_split_start: assert property (@(posedge sys_clk) disable iff (rst)
        (startReq && needSplit) |=> state_ff == CBS_LOW)
        else $error("byte split not taken");
    a_wide_start: assert property (@(posedge sys_clk) disable iff (rst)
        (startReq && !needSplit) |=> state_ff == CBS_WIDE)
        else $error("pass through not taken");
    a_low_first: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && state_ff == CBS_LOW) |-> !periphA0 && periphStrobe)
        else $error("low byte cycle addressed wrong byte");
    a_high_second: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && state_ff == CBS_HIGH) |-> periphA0 && periphStrobe)
        else $error("high byte cycle addressed wrong byte");
    a_high_lane: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && state_ff == CBS_HIGH && write_ff)
        |-> onboardPeripheralDataOe && onboardPeripheralData == wdata_ff[DATA_W-1:BYTE_W])
        else $error("high byte write lane wrong");
    a_read_merge: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && state_ff == CBS_HIGH && !write_ff)
        |=> processorDataBus == {$past(onboardPeripheralDataIn), $past(lowByte_ff)})
        else $error("merged word wrong");
    a_dma_reverse: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && dmaS2_ff) |=> !onboardPeripheralAddressOe)
        else $error("address buffer still driving during dma");
    a_mem_dir: assert property (@(posedge sys_clk) disable iff (rst)
        memoryDataBusOe |-> write_ff && mem_ff)
        else $error("memory buffer driven on read");
    a_ack_timing: assert property (@(posedge sys_clk) disable iff (rst)
        (startReq && needSplit) ##1 clkEn[*2] |=> cpuAck)
        else $error("split access ack late");

    c_split_read: cover property (@(posedge sys_clk) startReq && needSplit && !cpuWrite);
    c_split_write: cover property (@(posedge sys_clk) startReq && needSplit && cpuWrite);
    c_mem_write: cover property (@(posedge sys_clk) startReq && cpuMem && cpuWrite);
    c_dma: cover property (@(posedge sys_clk) dmaS2_ff);
endmodule

// >>> dv/cbs_far_side.sv
// far-side model: 8-bit peripheral, memory and system data sources
`timescale 1ns/100ps
module cbs_far_side (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] rdWord,
    input wire logic periphStrobe,
    input wire logic periphWrite,
    input wire logic periphA0,
    input wire logic [7:0] onboardPeripheralData,
    input wire logic onboardPeripheralDataOe,
    input wire logic [15:0] memoryDataBus,
    input wire logic memoryDataBusOe,
    input wire logic [15:0] systemDataBus,
    input wire logic systemDataBusOe,
    output logic [15:0] systemDataBusIn,
    output logic [15:0] memoryDataBusIn,
    output logic [7:0] onboardPeripheralDataIn,
    output logic [15:0] wrWord_ff,
    output logic [1:0] seq_ff
);
    // ************************************
    // read side
    // ************************************
    logic [7:0] junk_ff;
    wire logic rdByte = periphStrobe && !periphWrite;
    // released lines toggle so a stale byte never matches by luck
    assign onboardPeripheralDataIn = rdByte ? (periphA0 ? rdWord[15:8] : rdWord[7:0]) : junk_ff;
    assign memoryDataBusIn = memoryDataBusOe ? ~memoryDataBus : rdWord;
    assign systemDataBusIn = rdWord;
    // ************************************
    // write capture
    // ************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seq_ff <= 2'h0;
            junk_ff <= 8'ha5;
        end else begin
            junk_ff <= ~junk_ff;
            if (periphStrobe && onboardPeripheralDataOe) begin
                seq_ff <= {seq_ff[0], periphA0};
                if (periphA0) begin
                    wrWord_ff[15:8] <= onboardPeripheralData;
                end else begin
                    wrWord_ff[7:0] <= onboardPeripheralData;
                end
            end else if (memoryDataBusOe) begin
                wrWord_ff <= memoryDataBus;
            end else if (systemDataBusOe && periphWrite) begin
                wrWord_ff <= systemDataBus;
            end
        end
    end
endmodule

// >>> dv/cpu_bus_sizing_buffer_tb_top.sv
// self-checking bench for the bus sizing bridge
`timescale 1ns/100ps
module cpu_bus_sizing_buffer_tb_top;
    import cbs_pkg::*;
    logic sys_clk = 0, rst = 1, cpuReq = 0, cpuWrite = 0, cpuWord = 0, cpuMem = 0, target8 = 0, dmaActive = 0;
    logic clkEn = 1;
    logic [23:0] cpuAddr = '0;
    logic [15:0] cpuDin = '0, rdWord = '0, sysIn, memIn, procBus, wrWord;
    logic [16:1] perAddr;
    logic [7:0] perIn;
    logic [1:0] seq;
    logic [23:0] systemAddress;
    logic [19:1] latchedSystemAddress;
    logic [23:17] unlatchedHighAddress;
    logic [15:0] sysBus, memBus;
    logic [7:0] perBus;
    logic cpuAck, perAddrOe, sysOe, memOe, perOe, periphStrobe, periphWrite, periphA0;
    logic [16:0] expQ[$];
    logic [16:0] e;
    integer seed = 32'h16c3;
    int fails = 0, checks = 0;
    always #4 sys_clk = ~sys_clk;
    cbs_bridge dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .cpuReq(cpuReq), .cpuWrite(cpuWrite),
        .cpuWord(cpuWord), .cpuMem(cpuMem), .target8(target8), .dmaActive(dmaActive), .cpuAddr(cpuAddr),
        .processorDataBusIn(cpuDin), .systemDataBusIn(sysIn), .memoryDataBusIn(memIn),
        .onboardPeripheralDataIn(perIn), .onboardPeripheralAddressIn(16'h5a5a), .cpuAck(cpuAck),
        .processorDataBus(procBus), .systemAddress(systemAddress), .latchedSystemAddress(latchedSystemAddress),
        .unlatchedHighAddress(unlatchedHighAddress), .onboardPeripheralAddress(perAddr),
        .onboardPeripheralAddressOe(perAddrOe), .systemDataBus(sysBus), .systemDataBusOe(sysOe),
        .memoryDataBus(memBus), .memoryDataBusOe(memOe), .onboardPeripheralData(perBus),
        .onboardPeripheralDataOe(perOe), .periphStrobe(periphStrobe), .periphWrite(periphWrite),
        .periphA0(periphA0));
    cbs_far_side far (.sys_clk(sys_clk), .rst(rst), .rdWord(rdWord), .periphStrobe(periphStrobe),
        .periphWrite(periphWrite), .periphA0(periphA0), .onboardPeripheralData(perBus),
        .onboardPeripheralDataOe(perOe), .memoryDataBus(memBus), .memoryDataBusOe(memOe),
        .systemDataBus(sysBus), .systemDataBusOe(sysOe),
        .systemDataBusIn(sysIn), .memoryDataBusIn(memIn), .onboardPeripheralDataIn(perIn),
        .wrWord_ff(wrWord), .seq_ff(seq));
    // ************************************
    // checking
    // ************************************
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task results;
        if (fails == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (cpuAck === 1'b1) begin
            e = expQ.pop_front();
            if (e[16]) chk("read_data", {8'h00, e[15:0]}, {8'h00, procBus});
        end
    end
    // ************************************
    // stimulus
    // ************************************
    task automatic acc(input logic w, input logic m, input logic t8, input logic wd, input int lat);
        logic [23:0] a;
        logic [15:0] d;
        logic [7:0] lane;
        int n;
        a = $random(seed);
        d = $random(seed);
        // word accesses stay even; byte accesses try both lanes
        if (wd) a[0] = 1'b0;
        lane = a[0] ? d[15:8] : d[7:0];
        expQ.push_back({!w, wd ? d : {lane, lane}});
        @(posedge sys_clk);
        cpuReq <= 1'b1;
        cpuWrite <= w;
        cpuWord <= wd;
        cpuMem <= m;
        target8 <= t8;
        cpuAddr <= a;
        cpuDin <= d;
        rdWord <= d;
        @(posedge sys_clk);
        cpuReq <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (cpuAck !== 1'b1 && n < 10);
        // ack shows after edge n and is sampled high at the edge after
        chk("ack_latency", 24'(lat), 24'(n + 1));
        chk("sys_addr", a, systemAddress);
        chk("latched_addr", {5'h00, a[19:1]}, {5'h00, latchedSystemAddress});
        chk("high_addr", {17'h0_0000, a[23:17]}, {17'h0_0000, unlatchedHighAddress});
        chk("periph_addr", {8'h00, a[16:1]}, {8'h00, perAddr});
        if (w && wd) chk("write_data", {8'h00, d}, {8'h00, wrWord});
        if (w && !wd) chk("write_byte", {16'h0000, lane}, {16'h0000, a[0] ? wrWord[15:8] : wrWord[7:0]});
        if (w && t8 && !m && wd) chk("byte_order", 24'h00_0001, {22'h00_0000, seq});
        if (!w && t8 && !m && wd) begin
            chk("sys_data", {8'h00, d}, {8'h00, sysBus});
            chk("sys_data_oe", 24'h00_0001, {23'h00_0000, sysOe});
        end
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, 1'b0, 1'b1, 1'b1, 3);
            acc(1'b1, 1'b0, 1'b1, 1'b1, 3);
            acc(1'b0, 1'b1, i[0], 1'b1, 2); // memory never splits
            acc(1'b1, 1'b1, 1'b0, 1'b1, 2);
            acc(1'b0, 1'b0, 1'b0, 1'b1, 2);
            acc(1'b1, 1'b0, 1'b0, 1'b1, 2);
            acc(i[0], 1'b0, 1'b1, 1'b0, 2);
        end
        @(posedge sys_clk);
        dmaActive <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("addr_oe_dma", 24'h00_0000, {23'h00_0000, perAddrOe});
        @(posedge sys_clk);
        dmaActive <= 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        chk("addr_oe_cpu", 24'h00_0001, {23'h00_0000, perAddrOe});
        // clock enable low: a request and a new address must leave everything frozen
        @(posedge sys_clk);
        clkEn <= 1'b0;
        cpuReq <= 1'b1;
        cpuAddr <= ~cpuAddr;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("frozen_addr", ~cpuAddr, systemAddress);
        chk("frozen_high", {17'h0_0000, ~cpuAddr[23:17]}, {17'h0_0000, unlatchedHighAddress});
        @(posedge sys_clk);
        cpuReq <= 1'b0;
        clkEn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("resumed_high", {17'h0_0000, cpuAddr[23:17]}, {17'h0_0000, unlatchedHighAddress});
        results;
    end
    initial begin
        #50000;
        fails++;
        results;
    end
endmodule
